/* shared/chgsv_pkg.sv */
// constants and types for the charger supervision block
package chgsv_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CHGSV_REG_CHARGE_CTRL = 8'h02;
  localparam logic [7:0] CHGSV_REG_TIMER_CTRL = 8'h05;
  localparam logic [7:0] CHGSV_REG_SYS_CTRL = 8'h07;
  localparam logic [7:0] CHGSV_REG_FAULT = 8'h09;
  localparam logic [7:0] CHGSV_REG_MODE_CTRL = 8'h0a;
  localparam logic [7:0] CHGSV_REG_STATUS = 8'h0b;
  // field positions
  localparam int CHGSV_WD_KICK_BIT = 6;
  localparam int CHGSV_HOLD_BIT = 7;
  localparam int CHGSV_CHG_DISABLE_BIT = 0;
  localparam int CHGSV_WD_DSCHG_BIT = 7;
  localparam int CHGSV_WD_PER_LSB = 5;
  localparam int CHGSV_TERM_EN_BIT = 4;
  localparam int CHGSV_FAST_TMR_EN_BIT = 3;
  localparam int CHGSV_FAST_TMR_SEL_LSB = 1;
  localparam int CHGSV_KEEP_TAPER_BIT = 0;
  localparam int CHGSV_TJ_SEL_LSB = 4;
  localparam int CHGSV_THERM_FLAG_BIT = 1;
  localparam int CHGSV_MON_EN_BIT = 1;
  localparam int CHGSV_BOARD_SEL_BIT = 0;
  localparam int CHGSV_HIZ_BIT = 2;
  localparam int CHGSV_SWITCH_OFF_BIT = 3;
  // reset values
  localparam logic [7:0] CHGSV_CHARGE_CTRL_RST = 8'h80;
  localparam logic [7:0] CHGSV_TIMER_CTRL_RST = 8'hba;
  localparam logic [7:0] CHGSV_SYS_CTRL_RST = 8'h30;
  localparam logic [7:0] CHGSV_MODE_CTRL_RST = 8'h03;
  // timing
  localparam longint CHGSV_CLK_HZ = 10000000;
  localparam longint CHGSV_TERM_DELAY_MS = 3200;
  localparam longint CHGSV_TERM_DELAY_CYC = CHGSV_TERM_DELAY_MS * CHGSV_CLK_HZ / 1000;
  localparam longint CHGSV_PRE_TMR_HRS = 2;
  localparam longint CHGSV_PRE_TMR_CYC = CHGSV_PRE_TMR_HRS * 3600 * CHGSV_CLK_HZ;
  localparam int CHGSV_CNT_W = 40;
  // thermistor function decode
  typedef enum logic [1:0] {CHGSV_THERM_OFF, CHGSV_THERM_BATT, CHGSV_THERM_BOARD} chgsv_therm_e;
  // charge sequencer states
  typedef enum logic [2:0] {CHGSV_IDLE, CHGSV_PRE, CHGSV_FAST, CHGSV_TAPER, CHGSV_DONE, CHGSV_FAULT} chgsv_state_e;
endpackage

/* rtl/chgsv_top.sv */
// digital supervision of a single-cell charger: charge cycle, protections, timers, watchdog
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module chgsv_top import chgsv_pkg::*; #(
  parameter longint TERM_DELAY_CYC = CHGSV_TERM_DELAY_CYC,
  parameter longint PRE_TMR_CYC = CHGSV_PRE_TMR_CYC,
  parameter longint FAST_TMR_CYC0 = 64'd1000000000,
  parameter longint FAST_TMR_CYC1 = 64'd2000000000,
  parameter longint FAST_TMR_CYC2 = 64'd4000000000,
  parameter longint FAST_TMR_CYC3 = 64'd8000000000,
  parameter longint WD_CYC1 = 64'd400000000,
  parameter longint WD_CYC2 = 64'd800000000,
  parameter longint WD_CYC3 = 64'd1600000000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // analog comparator results, asynchronous
  input wire logic input_good_i,
  input wire logic battery_present_i,
  input wire logic batt_over_voltage_i,
  input wire logic batt_below_recharge_i,
  input wire logic batt_above_precharge_exit_i,
  input wire logic batt_above_lockout_i,
  input wire logic input_power_limiting_i,
  input wire logic sys_droop_i,
  input wire logic sys_below_batt_30mv_i,
  input wire logic sys_above_batt_20mv_i,
  input wire logic supplement_drop_over_i,
  input wire logic junction_at_limit_i,
  input wire logic junction_shutdown_i,
  input wire logic therm_in_window_i,
  input wire logic therm_below_hot_i,
  input wire logic current_below_term_i,
  input wire logic current_below_term_hys_i,
  // power stage controls
  output logic charge_enable_o,
  output logic charge_current_cut_o,
  output logic input_to_system_switch_o,
  output logic battery_switch_full_o,
  output logic battery_switch_regulate_o,
  output logic [1:0] junction_regulation_limit_o,
  output logic system_reset_o,
  output logic host_mode_o
);
  localparam int NS = 16;

  // three-flop synchronisers with agreement filter
  logic [NS-1:0] raw;
  logic [NS-1:0] s1, s2, s3, flt, next_flt;
  assign raw = {input_good_i, battery_present_i, batt_over_voltage_i, batt_below_recharge_i,
                batt_above_precharge_exit_i, batt_above_lockout_i, input_power_limiting_i, sys_droop_i,
                sys_below_batt_30mv_i, sys_above_batt_20mv_i, supplement_drop_over_i, junction_at_limit_i,
                junction_shutdown_i, therm_in_window_i, therm_below_hot_i,
                current_below_term_i & current_below_term_hys_i};
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      next_flt[i] = (s2[i] == s3[i]) ? s3[i] : flt[i];
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      flt <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      flt <= next_flt;
    end
  end
  logic in_good, batt_pres, batt_ov, below_rech, above_pre, above_lock, limiting, droop;
  logic sys_low, sys_high, sup_over, tj_lim, tj_shut, in_win, below_hot, below_term;
  assign {in_good, batt_pres, batt_ov, below_rech, above_pre, above_lock, limiting, droop,
          sys_low, sys_high, sup_over, tj_lim, tj_shut, in_win, below_hot, below_term} = flt;

  // control registers and host mode
  logic [7:0] charge_ctrl, timer_ctrl, sys_ctrl, mode_ctrl;
  logic [7:0] next_charge_ctrl, next_timer_ctrl, next_sys_ctrl, next_mode_ctrl;
  logic host_mode, next_host_mode;
  logic [CHGSV_CNT_W-1:0] wd_cnt, next_wd_cnt;
  logic wd_fault, next_wd_fault, wd_expire, wd_run;
  logic in_good_d, batt_pres_d;
  logic force_default;
  logic [1:0] wd_per;
  logic [CHGSV_CNT_W-1:0] wd_lim;
  assign wd_per = timer_ctrl[CHGSV_WD_PER_LSB +: 2];
  always_comb begin
    unique case (wd_per)
      2'd1: wd_lim = WD_CYC1[CHGSV_CNT_W-1:0];
      2'd2: wd_lim = WD_CYC2[CHGSV_CNT_W-1:0];
      2'd3: wd_lim = WD_CYC3[CHGSV_CNT_W-1:0];
      default: wd_lim = '0;
    endcase
  end
  // period 00 kills watchdog; discharge bit only matters without input
  assign wd_run = host_mode && (wd_per != 2'd0) && (in_good || timer_ctrl[CHGSV_WD_DSCHG_BIT]);
  assign wd_expire = wd_run && (wd_cnt >= wd_lim - 1'b1);
  // input refreshed with no battery, or battery reinserted with no input, or hold bit cleared
  assign force_default = (in_good && !in_good_d && !batt_pres) || (batt_pres && !batt_pres_d && !in_good)
                         || !charge_ctrl[CHGSV_HOLD_BIT];
  logic wr_hit_ctrl;
  assign wr_hit_ctrl = wr_i && (addr_i == CHGSV_REG_CHARGE_CTRL);
  always_comb begin
    next_charge_ctrl = charge_ctrl;
    next_timer_ctrl = timer_ctrl;
    next_sys_ctrl = sys_ctrl;
    next_mode_ctrl = mode_ctrl;
    next_host_mode = host_mode;
    next_wd_cnt = wd_run ? wd_cnt + 1'b1 : '0;
    next_wd_fault = wd_fault;
    if (wr_i) begin
      next_host_mode = 1'b1;
      unique case (addr_i)
        CHGSV_REG_CHARGE_CTRL: next_charge_ctrl = wdata_i & 8'hbf;
        CHGSV_REG_TIMER_CTRL: next_timer_ctrl = wdata_i;
        CHGSV_REG_SYS_CTRL: next_sys_ctrl = wdata_i;
        CHGSV_REG_MODE_CTRL: next_mode_ctrl = wdata_i & 8'h0f;
        default: ;
      endcase
      if (wr_hit_ctrl && wdata_i[CHGSV_WD_KICK_BIT]) begin
        next_wd_cnt = '0;
      end
    end
    if (rd_i && addr_i == CHGSV_REG_FAULT) begin
      next_wd_fault = 1'b0;
    end
    // expiry or forced default restores defaults; set wins over read clear
    if (wd_expire || force_default) begin
      next_charge_ctrl = CHGSV_CHARGE_CTRL_RST;
      next_timer_ctrl = CHGSV_TIMER_CTRL_RST;
      next_sys_ctrl = CHGSV_SYS_CTRL_RST;
      next_mode_ctrl = CHGSV_MODE_CTRL_RST;
      next_host_mode = 1'b0;
      next_wd_cnt = '0;
      next_wd_fault = next_wd_fault | wd_expire;
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      charge_ctrl <= CHGSV_CHARGE_CTRL_RST;
      timer_ctrl <= CHGSV_TIMER_CTRL_RST;
      sys_ctrl <= CHGSV_SYS_CTRL_RST;
      mode_ctrl <= CHGSV_MODE_CTRL_RST;
      host_mode <= 1'b0;
      wd_cnt <= '0;
      wd_fault <= 1'b0;
      in_good_d <= 1'b0;
      batt_pres_d <= 1'b0;
    end else begin
      charge_ctrl <= next_charge_ctrl;
      timer_ctrl <= next_timer_ctrl;
      sys_ctrl <= next_sys_ctrl;
      mode_ctrl <= next_mode_ctrl;
      host_mode <= next_host_mode;
      wd_cnt <= next_wd_cnt;
      wd_fault <= next_wd_fault;
      in_good_d <= in_good;
      batt_pres_d <= batt_pres;
    end
  end

  // thermistor function decode
  chgsv_therm_e therm_mode;
  always_comb begin
    if (!mode_ctrl[CHGSV_MON_EN_BIT]) begin
      therm_mode = CHGSV_THERM_OFF;
    end else if (mode_ctrl[CHGSV_BOARD_SEL_BIT]) begin
      therm_mode = CHGSV_THERM_BATT;
    end else begin
      therm_mode = CHGSV_THERM_BOARD;
    end
  end
  logic board_hot, hiz, chg_dis, sw_forced_off, term_en, keep_taper;
  assign board_hot = (therm_mode == CHGSV_THERM_BOARD) && below_hot;
  assign hiz = mode_ctrl[CHGSV_HIZ_BIT];
  assign chg_dis = charge_ctrl[CHGSV_CHG_DISABLE_BIT];
  assign sw_forced_off = mode_ctrl[CHGSV_SWITCH_OFF_BIT];
  assign term_en = timer_ctrl[CHGSV_TERM_EN_BIT];
  assign keep_taper = timer_ctrl[CHGSV_KEEP_TAPER_BIT];

  // supplement mode with hysteresis
  logic supplement, next_supplement;
  always_comb begin
    next_supplement = supplement;
    if (!in_good) begin
      next_supplement = 1'b0;
    end else if (!supplement && sys_low) begin
      next_supplement = 1'b1;
    end else if (supplement && sys_high) begin
      next_supplement = 1'b0;
    end
  end

  // charge sequencer, safety and termination timers
  chgsv_state_e state, next_state;
  logic [CHGSV_CNT_W-1:0] st_cnt, next_st_cnt, tm_cnt, next_tm_cnt, fast_lim;
  logic tmr_fault, next_tmr_fault, ov_fault, next_ov_fault;
  logic chg_dis_d, hiz_d, in_good_cd;
  logic charging, window_bad, start_trig, no_fault, restart_tmr, term_block;
  logic window_was_bad, next_window_was_bad;
  always_comb begin
    unique case (timer_ctrl[CHGSV_FAST_TMR_SEL_LSB +: 2])
      2'd0: fast_lim = FAST_TMR_CYC0[CHGSV_CNT_W-1:0];
      2'd1: fast_lim = FAST_TMR_CYC1[CHGSV_CNT_W-1:0];
      2'd2: fast_lim = FAST_TMR_CYC2[CHGSV_CNT_W-1:0];
      default: fast_lim = FAST_TMR_CYC3[CHGSV_CNT_W-1:0];
    endcase
  end
  assign charging = (state == CHGSV_PRE) || (state == CHGSV_FAST) || (state == CHGSV_TAPER);
  assign window_bad = (therm_mode == CHGSV_THERM_BATT) && !in_win;
  assign start_trig = (in_good && !in_good_cd) || (chg_dis_d && !chg_dis);
  assign no_fault = !window_bad && !tmr_fault && !batt_ov && !sw_forced_off && !board_hot;
  assign restart_tmr = (chg_dis_d && !chg_dis) || (hiz_d && !hiz);
  assign term_block = limiting || tj_lim || supplement;
  always_comb begin
    next_state = state;
    next_st_cnt = st_cnt + 1'b1;
    next_tm_cnt = '0;
    next_tmr_fault = tmr_fault;
    next_ov_fault = ov_fault | batt_ov;
    if (rd_i && addr_i == CHGSV_REG_FAULT) begin
      next_ov_fault = batt_ov;
      next_tmr_fault = 1'b0;
    end
    if (restart_tmr) begin
      next_tmr_fault = 1'b0;
    end
    unique case (state)
      CHGSV_IDLE, CHGSV_FAULT: begin
        if (in_good && !chg_dis && !hiz && start_trig && no_fault) begin
          next_state = CHGSV_PRE;
          next_st_cnt = '0;
        end
      end
      CHGSV_PRE: begin
        if (above_pre) begin
          next_state = CHGSV_FAST;
          next_st_cnt = '0;
        end else if (st_cnt >= PRE_TMR_CYC[CHGSV_CNT_W-1:0] - 1'b1) begin
          next_state = CHGSV_FAULT;
          next_tmr_fault = 1'b1;
        end
      end
      CHGSV_FAST, CHGSV_TAPER: begin
        if (timer_ctrl[CHGSV_FAST_TMR_EN_BIT] && st_cnt >= fast_lim - 1'b1) begin
          next_state = CHGSV_FAULT;
          next_tmr_fault = 1'b1;
        end else if (term_en && below_term && !term_block) begin
          next_tm_cnt = tm_cnt + 1'b1;
          if (tm_cnt >= TERM_DELAY_CYC[CHGSV_CNT_W-1:0] - 1'b1) begin
            next_state = keep_taper ? CHGSV_TAPER : CHGSV_DONE;
            next_tm_cnt = '0;
          end
        end
      end
      CHGSV_DONE: begin
        if (below_rech && in_good && term_en && !keep_taper && no_fault) begin
          next_state = CHGSV_PRE;
          next_st_cnt = '0;
        end
      end
      default: next_state = CHGSV_IDLE;
    endcase
    // suspensions override progress
    if (charging && (batt_ov || window_bad || board_hot || tj_shut || chg_dis || hiz || !in_good
        || sw_forced_off)) begin
      next_state = batt_ov ? CHGSV_FAULT : CHGSV_IDLE;
    end
    if (restart_tmr && charging) begin
      next_st_cnt = '0;
    end
    // resume after window returns without a new trigger
    if (state == CHGSV_IDLE && in_good && !chg_dis && !hiz && no_fault && !tj_shut && in_good_cd
        && !start_trig && window_was_bad) begin
      next_state = CHGSV_PRE;
      next_st_cnt = '0;
    end
  end
  // remembers a window pause so charging resumes without a new trigger
  always_comb begin
    next_window_was_bad = window_was_bad;
    if (charging && window_bad) begin
      next_window_was_bad = 1'b1;
    end else if (charging || !in_good || chg_dis) begin
      next_window_was_bad = 1'b0;
    end
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= CHGSV_IDLE;
      st_cnt <= '0;
      tm_cnt <= '0;
      tmr_fault <= 1'b0;
      ov_fault <= 1'b0;
      chg_dis_d <= 1'b0;
      hiz_d <= 1'b0;
      in_good_cd <= 1'b0;
      supplement <= 1'b0;
      window_was_bad <= 1'b0;
    end else begin
      state <= next_state;
      st_cnt <= next_st_cnt;
      tm_cnt <= next_tm_cnt;
      tmr_fault <= next_tmr_fault;
      ov_fault <= next_ov_fault;
      chg_dis_d <= chg_dis;
      hiz_d <= hiz;
      in_good_cd <= in_good;
      supplement <= next_supplement;
      window_was_bad <= next_window_was_bad;
    end
  end

  // registered outputs and read data
  logic [7:0] next_rdata;
  always_comb begin
    unique case (addr_i)
      CHGSV_REG_CHARGE_CTRL: next_rdata = charge_ctrl;
      CHGSV_REG_TIMER_CTRL: next_rdata = timer_ctrl;
      CHGSV_REG_SYS_CTRL: next_rdata = sys_ctrl;
      CHGSV_REG_MODE_CTRL: next_rdata = mode_ctrl;
      CHGSV_REG_FAULT: next_rdata = {4'h0, ov_fault, tmr_fault, board_hot | window_bad, wd_fault};
      CHGSV_REG_STATUS: next_rdata = {supplement, host_mode, in_good, 2'b00, 3'(state)};
      default: next_rdata = 8'h00;
    endcase
    if (!rd_i) begin
      next_rdata = 8'h00;
    end
  end
  logic sw_in_off, dschg;
  assign sw_in_off = tj_shut || board_hot || hiz || !in_good;
  assign dschg = !in_good;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
      charge_enable_o <= 1'b0;
      charge_current_cut_o <= 1'b0;
      input_to_system_switch_o <= 1'b0;
      battery_switch_full_o <= 1'b0;
      battery_switch_regulate_o <= 1'b0;
      junction_regulation_limit_o <= 2'b00;
      system_reset_o <= 1'b0;
      host_mode_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      charge_enable_o <= charging && !(state == CHGSV_TAPER && 1'b0);
      charge_current_cut_o <= (limiting && droop) || tj_lim;
      input_to_system_switch_o <= !sw_in_off;
      // battery on in discharge only above lockout; supplement full on past the drop
      battery_switch_full_o <= !tj_shut && !board_hot && ((dschg && batt_pres && above_lock)
                               || (supplement && sup_over));
      battery_switch_regulate_o <= supplement && !sup_over && !tj_shut && !board_hot;
      junction_regulation_limit_o <= sys_ctrl[CHGSV_TJ_SEL_LSB +: 2];
      system_reset_o <= wd_expire;
      host_mode_o <= host_mode;
    end
  end

  // assertions
  property p_wr_host;
    @(posedge clock_i) disable iff (!rst_b_i) (wr_i && !force_default && !wd_expire) |=> host_mode;
  endproperty
  a_wr_host: assert property (p_wr_host) else $error("write did not enter host mode");
  property p_wd_zero;
    @(posedge clock_i) disable iff (!rst_b_i) (wd_per == 2'd0) |-> !wd_run;
  endproperty
  a_wd_zero: assert property (p_wd_zero) else $error("watchdog runs with zero period");
  property p_wd_dschg;
    @(posedge clock_i) disable iff (!rst_b_i) (!in_good && !timer_ctrl[CHGSV_WD_DSCHG_BIT]) |-> !wd_run;
  endproperty
  a_wd_dschg: assert property (p_wd_dschg) else $error("watchdog runs in discharge while off");
  property p_expire_default;
    @(posedge clock_i) disable iff (!rst_b_i) wd_expire |=> (!host_mode && timer_ctrl == CHGSV_TIMER_CTRL_RST);
  endproperty
  a_expire_default: assert property (p_expire_default) else $error("expiry kept host settings");
  property p_tshut;
    @(posedge clock_i) disable iff (!rst_b_i) tj_shut |=> (!input_to_system_switch_o && !battery_switch_full_o);
  endproperty
  a_tshut: assert property (p_tshut) else $error("switches on at junction shutdown");
  property p_ov;
    @(posedge clock_i) disable iff (!rst_b_i) (batt_ov && charging) |=> (state == CHGSV_FAULT && ov_fault);
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage did not suspend charge");
  property p_lock;
    @(posedge clock_i) disable iff (!rst_b_i) (dschg && !supplement && !above_lock) |=> !battery_switch_full_o;
  endproperty
  a_lock: assert property (p_lock) else $error("battery switch on below lockout");
  sequence s_done_enter;
    (state == CHGSV_FAST || state == CHGSV_TAPER) ##1 (state == CHGSV_DONE);
  endsequence
  property p_term_block;
    @(posedge clock_i) disable iff (!rst_b_i) s_done_enter |-> $past(!term_block && term_en);
  endproperty
  a_term_block: assert property (p_term_block) else $error("terminated while blocked");
endmodule

/* tb/chgsv_top_tb.sv */
// self-checking bench for the charger supervision block
`timescale 1ns/1ps
module chgsv_top_tb import chgsv_pkg::*;;
  logic clock_i, rst_b_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i, rdata_o, d;
  logic input_good_i, battery_present_i, batt_over_voltage_i, batt_below_recharge_i, batt_above_precharge_exit_i;
  logic batt_above_lockout_i, input_power_limiting_i, sys_droop_i, sys_below_batt_30mv_i, sys_above_batt_20mv_i;
  logic supplement_drop_over_i, junction_at_limit_i, junction_shutdown_i, therm_in_window_i, therm_below_hot_i;
  logic current_below_term_i, current_below_term_hys_i;
  logic charge_enable_o, charge_current_cut_o, input_to_system_switch_o, battery_switch_full_o;
  logic battery_switch_regulate_o, system_reset_o, host_mode_o;
  logic [1:0] junction_regulation_limit_o;
  int err_total, n_checks;
  logic got_pulse;
  // short counts keep the run brief; expectations use the same figures
  // only the selections the bench uses are shortened; the others keep their defaults
  chgsv_top #(.TERM_DELAY_CYC(20), .PRE_TMR_CYC(100), .FAST_TMR_CYC1(5000), .WD_CYC1(60)) chgsv_top_i (
    .clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .input_good_i, .battery_present_i,
    .batt_over_voltage_i, .batt_below_recharge_i, .batt_above_precharge_exit_i, .batt_above_lockout_i,
    .input_power_limiting_i, .sys_droop_i, .sys_below_batt_30mv_i, .sys_above_batt_20mv_i,
    .supplement_drop_over_i, .junction_at_limit_i, .junction_shutdown_i, .therm_in_window_i,
    .therm_below_hot_i, .current_below_term_i, .current_below_term_hys_i, .charge_enable_o,
    .charge_current_cut_o, .input_to_system_switch_o, .battery_switch_full_o, .battery_switch_regulate_o,
    .junction_regulation_limit_o, .system_reset_o, .host_mode_o);
  // 10 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task results;
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one-cycle write strobe beside address and data
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    rd(a);
    chk(d & mask, exp);
  endtask
  // bounded poll of the sequencer state field
  task wait_state(input logic [2:0] s, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd(CHGSV_REG_STATUS);
      if (d[2:0] === s) break;
    end
    if (i == lim) begin
      err_total++;
      $display("[ERR] %0t state %0d not reached", $time, s);
      results();
    end
  endtask
  // hang guard
  initial begin
    #9000000;
    err_total++;
    $display("[ERR] %0t run limit", $time);
    results();
  end
  initial begin
    {wr_i, rd_i, addr_i, wdata_i, d, got_pulse} = '0;
    {input_good_i, batt_over_voltage_i, batt_below_recharge_i, batt_above_precharge_exit_i} = '0;
    {batt_above_lockout_i, input_power_limiting_i, sys_droop_i, sys_below_batt_30mv_i} = '0;
    {sys_above_batt_20mv_i, supplement_drop_over_i, junction_at_limit_i, junction_shutdown_i} = '0;
    {therm_below_hot_i, current_below_term_i, current_below_term_hys_i} = '0;
    battery_present_i = 1'b1;
    therm_in_window_i = 1'b1;
    err_total = 0;
    n_checks = 0;
    rst_b_i = 1'b0;
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    cyc(2);
    // defaults after power-on, kick bit reads 0, unmapped reads 0
    chk({7'h0, host_mode_o}, 8'h00);
    rchk(CHGSV_REG_CHARGE_CTRL, CHGSV_CHARGE_CTRL_RST, 8'hff);
    rchk(CHGSV_REG_TIMER_CTRL, CHGSV_TIMER_CTRL_RST, 8'hff);
    rchk(CHGSV_REG_SYS_CTRL, CHGSV_SYS_CTRL_RST, 8'hff);
    rchk(CHGSV_REG_MODE_CTRL, CHGSV_MODE_CTRL_RST, 8'hff);
    rchk(8'h30, 8'h00, 8'hff);
    // period 00 stops the watchdog; the write itself enters host mode
    wr(CHGSV_REG_TIMER_CTRL, 8'h9a);
    cyc(2);
    chk({7'h0, host_mode_o}, 8'h01);
    for (int i = 3; i >= 0; i--) begin
      wr(CHGSV_REG_SYS_CTRL, 8'(i << 4));
      cyc(2);
      chk({6'h0, junction_regulation_limit_o}, 8'(i));
    end
    // discharge: battery switch waits for lockout threshold
    cyc(10);
    chk({7'h0, battery_switch_full_o}, 8'h00);
    @(posedge clock_i) batt_above_lockout_i <= 1'b1;
    cyc(10);
    chk({7'h0, battery_switch_full_o}, 8'h01);
    // input arrives: fresh cycle in precharge, then fast charge
    @(posedge clock_i) input_good_i <= 1'b1;
    wait_state(3'd1, 30);
    chk({7'h0, charge_enable_o}, 8'h01);
    @(posedge clock_i) batt_above_precharge_exit_i <= 1'b1;
    wait_state(3'd2, 30);
    @(posedge clock_i) input_power_limiting_i <= 1'b1;
    cyc(10);
    chk({7'h0, charge_current_cut_o}, 8'h00);
    @(posedge clock_i) sys_droop_i <= 1'b1;
    cyc(10);
    chk({7'h0, charge_current_cut_o}, 8'h01);
    @(posedge clock_i) sys_droop_i <= 1'b0;
    // supplement entry, full switch-on, exit
    @(posedge clock_i) sys_below_batt_30mv_i <= 1'b1;
    cyc(10);
    rchk(CHGSV_REG_STATUS, 8'h80, 8'h80);
    chk({7'h0, battery_switch_regulate_o}, 8'h01);
    @(posedge clock_i) supplement_drop_over_i <= 1'b1;
    cyc(10);
    chk({7'h0, battery_switch_full_o}, 8'h01);
    @(posedge clock_i) {sys_below_batt_30mv_i, supplement_drop_over_i, sys_above_batt_20mv_i} <= 3'b001;
    cyc(10);
    rchk(CHGSV_REG_STATUS, 8'h00, 8'h80);
    // low current under limiting must not terminate
    @(posedge clock_i) {current_below_term_i, current_below_term_hys_i} <= 2'b11;
    cyc(80);
    rchk(CHGSV_REG_STATUS, 8'h02, 8'h07);
    @(posedge clock_i) input_power_limiting_i <= 1'b0;
    wait_state(3'd4, 40);
    chk({7'h0, charge_enable_o}, 8'h00);
    @(posedge clock_i) {current_below_term_i, current_below_term_hys_i, batt_below_recharge_i} <= 3'b001;
    wait_state(3'd2, 30);
    @(posedge clock_i) batt_below_recharge_i <= 1'b0;
    // battery thermistor window pauses and resumes charge
    @(posedge clock_i) therm_in_window_i <= 1'b0;
    cyc(10);
    chk({7'h0, charge_enable_o}, 8'h00);
    @(posedge clock_i) therm_in_window_i <= 1'b1;
    cyc(10);
    chk({7'h0, charge_enable_o}, 8'h01);
    @(posedge clock_i) batt_over_voltage_i <= 1'b1;
    cyc(10);
    chk({7'h0, charge_enable_o}, 8'h00);
    rchk(CHGSV_REG_FAULT, 8'h08, 8'h08);
    @(posedge clock_i) batt_over_voltage_i <= 1'b0;
    // board protection mode: both switches off while hot
    wr(CHGSV_REG_MODE_CTRL, 8'h02);
    @(posedge clock_i) therm_below_hot_i <= 1'b1;
    cyc(10);
    chk({6'h0, input_to_system_switch_o, battery_switch_full_o}, 8'h00);
    rchk(CHGSV_REG_FAULT, 8'h02, 8'h02);
    @(posedge clock_i) therm_below_hot_i <= 1'b0;
    cyc(10);
    chk({7'h0, input_to_system_switch_o}, 8'h01);
    wr(CHGSV_REG_MODE_CTRL, 8'h03);
    @(posedge clock_i) junction_shutdown_i <= 1'b1;
    cyc(10);
    chk({6'h0, input_to_system_switch_o, battery_switch_full_o}, 8'h00);
    @(posedge clock_i) {junction_shutdown_i, batt_above_precharge_exit_i} <= 2'b00;
    rd(CHGSV_REG_FAULT);
    // toggling charge off and on restarts the precharge timer
    wr(CHGSV_REG_CHARGE_CTRL, 8'h81);
    wr(CHGSV_REG_CHARGE_CTRL, 8'h80);
    wait_state(3'd1, 30);
    wait_state(3'd5, 80);
    rchk(CHGSV_REG_FAULT, 8'h04, 8'h04);
    // watchdog kick keeps host mode, then expiry restores defaults
    wr(CHGSV_REG_TIMER_CTRL, 8'hba);
    cyc(30);
    wr(CHGSV_REG_CHARGE_CTRL, 8'hc0);
    cyc(40);
    chk({7'h0, host_mode_o}, 8'h01);
    for (int i = 0; i < 100 && !got_pulse; i++) begin
      cyc(1);
      got_pulse = (system_reset_o === 1'b1);
    end
    chk({7'h0, got_pulse}, 8'h01);
    cyc(2);
    chk({7'h0, host_mode_o}, 8'h00);
    rchk(CHGSV_REG_SYS_CTRL, CHGSV_SYS_CTRL_RST, 8'hff);
    // clearing the hold bit falls back to default mode
    wr(CHGSV_REG_TIMER_CTRL, 8'h9a);
    wr(CHGSV_REG_CHARGE_CTRL, 8'h00);
    cyc(3);
    chk({7'h0, host_mode_o}, 8'h00);
    results();
  end
endmodule
